/* File: rtl/fpp_host.sv */
// Purpose: host controller that reads a 256 x 4 fuse prom and programs bits
// Assumes: pulse_cyc default is 100 us at 20 MHz; shorten it in simulation
// Notes: one request at a time; busy stays high until done pulses
module fpp_host
	import fpp_pkg::*;
#(
	parameter int PULSE_CYCLES = PULSE_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// user requests
	input wire logic rd_req,
	input wire logic prog_req,
	input wire logic [fpp_pkg::ADDR_W-1:0] req_addr,
	input wire logic [fpp_pkg::BIT_W-1:0] req_bit,
	output logic busy,
	output logic done,
	output logic fail,
	output logic [fpp_pkg::DATA_W-1:0] rd_data,
	output logic [fpp_pkg::TRY_W-1:0] tries,
	// device pins
	output logic [fpp_pkg::ADDR_W-1:0] word_address,
	output logic select_b,
	output logic select_pull,
	output logic program_supply,
	output logic [fpp_pkg::DATA_W-1:0] word_out_o,
	output logic [fpp_pkg::DATA_W-1:0] word_out_oe,
	input wire logic [fpp_pkg::DATA_W-1:0] word_out_i
);
	import fpp_pkg::*;

	// pulse_width_a needs eight cycles of pulse; the counter caps the top end
	if (PULSE_CYCLES < 8 || PULSE_CYCLES >= (1 << CNT_W)) begin : g_bad_pulse
		$error("pulse cycles out of range");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		fpp_state_type st;
		logic [CNT_W-1:0] cnt;
		logic [TRY_W-1:0] tries;
		logic prog;
		logic [BIT_W-1:0] bsel;
		logic busy;
		logic done;
		logic fail;
		logic [DATA_W-1:0] rd_data;
		logic [ADDR_W-1:0] addr;
		logic select_b;
		logic select_pull;
		logic supply;
		logic [DATA_W-1:0] out_oe;
	} fpp_regs_type;

	fpp_regs_type r_ff, nxt_r;
	logic [DATA_W-1:0] sense;

	fpp_sync #(.W(DATA_W)) u_sync (
		.clock(clock),
		.rst_b(rst_b),
		.d(word_out_i),
		.q(sense)
	);

	function automatic logic [DATA_W-1:0] bit_onehot(input logic [BIT_W-1:0] b);
		bit_onehot = DATA_W'(1) << b;
	endfunction

	always_comb begin
		nxt_r = r_ff;
		nxt_r.done = 1'b0;
		case (r_ff.st)
			ST_IDLE: begin
				if (rd_req || prog_req) begin
					nxt_r.prog = prog_req && !rd_req;
					nxt_r.addr = req_addr;
					nxt_r.bsel = req_bit;
					nxt_r.tries = '0;
					nxt_r.busy = 1'b1;
					nxt_r.fail = 1'b0;
					nxt_r.select_b = 1'b1;
					nxt_r.cnt = '0;
					nxt_r.st = (prog_req && !rd_req) ? ST_ADDR : ST_READ;
					if (!(prog_req && !rd_req))
						nxt_r.select_b = 1'b0;
				end
			end
			ST_ADDR: begin
				// address held a full setup before the supply rises
				if (r_ff.cnt >= CNT_W'(SETUP_CYC)) begin
					nxt_r.supply = 1'b1;
					nxt_r.cnt = '0;
					nxt_r.st = ST_SUPPLY;
				end else
					nxt_r.cnt = r_ff.cnt + 1'b1;
			end
			ST_SUPPLY: begin
				if (r_ff.cnt >= CNT_W'(SETTLE_CYC)) begin
					nxt_r.out_oe = bit_onehot(r_ff.bsel);
					nxt_r.cnt = '0;
					nxt_r.st = ST_DRIVE;
				end else
					nxt_r.cnt = r_ff.cnt + 1'b1;
			end
			ST_DRIVE: begin
				if (r_ff.cnt >= CNT_W'(SETTLE_CYC)) begin
					nxt_r.select_pull = 1'b1;
					nxt_r.tries = r_ff.tries + 1'b1;
					nxt_r.cnt = '0;
					nxt_r.st = ST_PULSE;
				end else
					nxt_r.cnt = r_ff.cnt + 1'b1;
			end
			ST_PULSE: begin
				if (r_ff.cnt >= CNT_W'(PULSE_CYCLES - 1)) begin
					nxt_r.select_pull = 1'b0;
					nxt_r.cnt = '0;
					nxt_r.st = ST_DROP;
				end else
					nxt_r.cnt = r_ff.cnt + 1'b1;
			end
			ST_DROP: begin
				// staged release: output first, then the supply, then select_b goes low for verify
				nxt_r.cnt = r_ff.cnt + 1'b1;
				if (r_ff.cnt == CNT_W'(SETTLE_CYC))
					nxt_r.out_oe = '0;
				if (r_ff.cnt == CNT_W'(2 * SETTLE_CYC))
					nxt_r.supply = 1'b0;
				if (r_ff.cnt >= CNT_W'(3 * SETTLE_CYC)) begin
					nxt_r.select_b = 1'b0;
					nxt_r.cnt = '0;
					nxt_r.st = ST_VERIFY;
				end
			end
			ST_VERIFY: begin
				// wait covers access time plus the two sync flops
				if (r_ff.cnt >= CNT_W'(READ_CYC + 2)) begin
					nxt_r.select_b = 1'b1;
					nxt_r.cnt = '0;
					if (!sense[r_ff.bsel]) begin
						nxt_r.st = ST_DONE;
					end else if (r_ff.tries >= TRY_W'(MAX_TRIES)) begin
						nxt_r.fail = 1'b1;
						nxt_r.st = ST_DONE;
					end else
						nxt_r.st = ST_ADDR;
				end else
					nxt_r.cnt = r_ff.cnt + 1'b1;
			end
			ST_READ: begin
				if (r_ff.cnt >= CNT_W'(READ_CYC + 2)) begin
					nxt_r.rd_data = sense;
					nxt_r.select_b = 1'b1;
					nxt_r.cnt = '0;
					nxt_r.st = ST_DONE;
				end else
					nxt_r.cnt = r_ff.cnt + 1'b1;
			end
			ST_DONE: begin
				nxt_r.busy = 1'b0;
				nxt_r.done = 1'b1;
				nxt_r.st = ST_IDLE;
			end
			default: begin
				nxt_r.st = ST_IDLE;
				nxt_r.select_b = 1'b1;
				nxt_r.select_pull = 1'b0;
				nxt_r.supply = 1'b0;
				nxt_r.out_oe = '0;
				nxt_r.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			r_ff <= '{st: ST_IDLE, select_b: 1'b1, default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign busy = r_ff.busy;
	assign done = r_ff.done;
	assign fail = r_ff.fail;
	assign rd_data = r_ff.rd_data;
	assign tries = r_ff.tries;
	assign word_address = r_ff.addr;
	assign select_b = r_ff.select_b;
	assign select_pull = r_ff.select_pull;
	assign program_supply = r_ff.supply;
	assign word_out_o = r_ff.out_oe;
	assign word_out_oe = r_ff.out_oe;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence supply_rise_s;
		$rose(r_ff.supply);
	endsequence

	addr_before_supply_a: assert property (@(posedge clock) disable iff (!rst_b)
		supply_rise_s |-> $stable(r_ff.addr) && $past(r_ff.st) == ST_ADDR)
		else $error("supply rose without address setup");
	one_bit_drive_a: assert property (@(posedge clock) disable iff (!rst_b)
		r_ff.out_oe != '0 |-> $onehot(r_ff.out_oe) && r_ff.supply)
		else $error("output driven without supply or more than one bit");
	pulse_needs_drive_a: assert property (@(posedge clock) disable iff (!rst_b)
		r_ff.select_pull |-> r_ff.supply && r_ff.out_oe != '0 && r_ff.select_b)
		else $error("pulse without supply and driven output");
	pulse_width_a: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(r_ff.select_pull) |-> r_ff.select_pull [*8])
		else $error("pulse shorter than expected");
	release_order_a: assert property (@(posedge clock) disable iff (!rst_b)
		$fell(r_ff.supply) |-> r_ff.out_oe == '0 && !r_ff.select_pull)
		else $error("supply dropped before output and pulse removed");
	verify_select_a: assert property (@(posedge clock) disable iff (!rst_b)
		r_ff.st == ST_VERIFY |-> r_ff.prog && !r_ff.select_b && !r_ff.supply && r_ff.out_oe == '0)
		else $error("verify not at normal levels");
	try_limit_a: assert property (@(posedge clock) disable iff (!rst_b)
		r_ff.tries <= TRY_W'(MAX_TRIES))
		else $error("too many attempts");
	read_select_a: assert property (@(posedge clock) disable iff (!rst_b)
		r_ff.st == ST_READ |-> !r_ff.select_b && !r_ff.supply)
		else $error("read without select");
endmodule

/* File: rtl/fpp_pkg.sv */
// Purpose: constants for the fuse prom programmer and reader (host side)
// Assumes: 20 MHz clock, one device of 256 x 4 behind the pins
// Notes: analog levels are outside the logic; pins are logic-level stand-ins
package fpp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 4;
	localparam int BIT_W = 2;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SETUP_NS = 20;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_US = 100;
	localparam int PULSE_CYC = (PULSE_US * 1000) / CLK_PERIOD_NS;
	localparam int SETTLE_US = 1;
	localparam int SETTLE_CYC = (SETTLE_US * 1000) / CLK_PERIOD_NS;
	localparam int ACS_NS = 8;
	localparam int READ_CYC = (ACS_NS + 20 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MAX_TRIES = 8;
	localparam int CNT_W = 16;
	localparam int TRY_W = 4;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_SUPPLY = 9'h004,
		ST_DRIVE = 9'h008,
		ST_PULSE = 9'h010,
		ST_DROP = 9'h020,
		ST_VERIFY = 9'h040,
		ST_READ = 9'h080,
		ST_DONE = 9'h100
	} fpp_state_type;
endpackage

/* File: rtl/fpp_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input changes asynchronously to clock
// Notes: first stage read only by the second
module fpp_sync #(
	parameter int W = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule

/* File: tb/fpp_prom_mdl.sv */
// Purpose: behavioural 256 x 4 fuse prom facing the host controller
// Assumes: pins are logic-level stand-ins for the analog levels
// Notes: refuse_left lets the bench make a number of blows fail
module fpp_prom_mdl
	import fpp_pkg::*;
(
	// address and control
	input wire logic [fpp_pkg::ADDR_W-1:0] word_address,
	input wire logic select_b,
	input wire logic select_pull,
	input wire logic program_supply,
	// data pins
	input wire logic [fpp_pkg::DATA_W-1:0] word_out_o,
	input wire logic [fpp_pkg::DATA_W-1:0] word_out_oe,
	output logic [fpp_pkg::DATA_W-1:0] word_out_i,
	// sequence watch
	output logic seq_err
);
	timeunit 1ns;
	timeprecision 100ps;
	import fpp_pkg::*;
	logic [DATA_W-1:0] mem [256];
	logic [DATA_W-1:0] dev_q;
	logic [DATA_W-1:0] word_q;
	int refuse_left;
	realtime t_addr;
	initial begin
		foreach (mem[i]) mem[i] = 4'hF;
		refuse_left = 0;
		seq_err = 1'b0;
		t_addr = 0.0;
	end
	// slowest legal access: 20 ns from address, 8 ns from select, so the host must wait
	assign #12 word_q = mem[word_address];
	assign #8 dev_q = select_b ? 4'h0 : word_q;
	assign word_out_i = (word_out_oe & word_out_o) | (~word_out_oe & dev_q);
	always @(word_address) begin
		t_addr = $realtime;
		if (program_supply) seq_err = 1'b1;
	end
	always @(posedge program_supply) begin
		if ($realtime - t_addr < 20.0 || word_out_oe != 4'h0) seq_err = 1'b1;
	end
	always @(negedge program_supply) begin
		if (select_pull || word_out_oe != 4'h0) seq_err = 1'b1;
	end
	always @(posedge select_pull) begin
		if (!program_supply || !$onehot(word_out_oe) || (word_out_o & word_out_oe) == 4'h0)
			seq_err = 1'b1;
		else if (refuse_left > 0)
			refuse_left--;
		else
			mem[word_address] = mem[word_address] & ~word_out_oe;
	end
endmodule

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the fuse prom host controller
// Assumes: pulse shortened to 10 cycles
// Notes: one request at a time, outputs sampled on the falling edge
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import fpp_pkg::*;
	logic clock, rst_b, rd_req, prog_req, busy, done, fail, seq_err;
	logic select_b, select_pull, program_supply;
	logic [ADDR_W-1:0] req_addr, word_address;
	logic [BIT_W-1:0] req_bit;
	logic [DATA_W-1:0] rd_data, word_out_o, word_out_oe, word_out_i;
	logic [TRY_W-1:0] tries;
	int n_errors = 0;
	int check_count = 0;
	fpp_host #(.PULSE_CYCLES(10)) dut (.clock(clock), .rst_b(rst_b), .rd_req(rd_req),
		.prog_req(prog_req), .req_addr(req_addr), .req_bit(req_bit), .busy(busy),
		.done(done), .fail(fail), .rd_data(rd_data), .tries(tries),
		.word_address(word_address), .select_b(select_b), .select_pull(select_pull),
		.program_supply(program_supply), .word_out_o(word_out_o),
		.word_out_oe(word_out_oe), .word_out_i(word_out_i));
	fpp_prom_mdl mdl (.word_address(word_address), .select_b(select_b),
		.select_pull(select_pull), .program_supply(program_supply),
		.word_out_o(word_out_o), .word_out_oe(word_out_oe), .word_out_i(word_out_i),
		.seq_err(seq_err));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one read or program request, waiting for done under a bound
	task automatic op(input logic rd, input logic [7:0] a, input logic [1:0] b);
		int n;
		n = 0;
		@(posedge clock);
		rd_req <= rd;
		prog_req <= !rd;
		req_addr <= a;
		req_bit <= b;
		@(posedge clock);
		rd_req <= 1'b0;
		prog_req <= 1'b0;
		@(negedge clock);
		chk({3'h0, busy}, 4'h1);
		while (done !== 1'b1 && n < 5000) begin
			@(negedge clock);
			n++;
		end
		if (n >= 5000) begin
			n_errors++;
			print_verdict();
		end
		chk({3'h0, busy}, 4'h0);
	endtask
	task automatic t_blank();
		op(1'b1, 8'h00, 2'h0);
		chk(rd_data, 4'hF);
		chk({3'h0, select_b}, 4'h1);
		op(1'b1, 8'hFF, 2'h0);
		chk(rd_data, 4'hF);
		$display("test blank done");
	endtask
	task automatic t_prog();
		op(1'b0, 8'h5A, 2'h2);
		chk({3'h0, fail}, 4'h0);
		chk(tries, 4'h1);
		op(1'b1, 8'h5A, 2'h0);
		chk(rd_data, 4'hB);
		op(1'b0, 8'h5A, 2'h0);
		op(1'b1, 8'h5A, 2'h0);
		chk(rd_data, 4'hA);
		op(1'b1, 8'h5B, 2'h0);
		chk(rd_data, 4'hF);
		$display("test program done");
	endtask
	task automatic t_retry();
		mdl.refuse_left = 2;
		op(1'b0, 8'h3C, 2'h3);
		chk({3'h0, fail}, 4'h0);
		chk(tries, 4'h3);
		op(1'b1, 8'h3C, 2'h0);
		chk(rd_data, 4'h7);
		$display("test retry done");
	endtask
	task automatic t_exhaust();
		mdl.refuse_left = 8;
		op(1'b0, 8'h81, 2'h1);
		chk({3'h0, fail}, 4'h1);
		chk(tries, 4'h8);
		op(1'b1, 8'h81, 2'h0);
		chk(rd_data, 4'hF);
		chk({3'h0, seq_err}, 4'h0);
		$display("test exhaust done");
	endtask
	initial begin
		rst_b = 1'b0;
		rd_req = 1'b0;
		prog_req = 1'b0;
		req_addr = 8'h00;
		req_bit = 2'h0;
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		t_blank();
		t_prog();
		t_retry();
		t_exhaust();
		print_verdict();
	end
endmodule
